// ===== octal_dac_control_registers.sv
/*
 * command decoder and register bank of an octal 8-bit converter.
 * holds the eight code registers, the global and per-pair control
 * registers, the preset register, and drives the converter inputs,
 * amplifier enables and speed selects.
 * assumes the serial host keeps frame timing; preset and load pins are
 * asynchronous and are synchronised to mclk here.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - address 8 writes global control
// - d4 full shutdown, d3 echo enable
// - d0 selects binary or twos complement
// - address 9: d7..d4 pair shutdown bits
// - pair shutdown disables both pair amplifiers
// - d3..d0 pair speed, one is fast
// - address 10 stores shared preset code
// - low preset pin applies preset everywhere
// - unwritten preset gives zero scale
// - 12..15 write code and complement
// - 16-bit word, address in top nibble
// - codes 0..7 from d11..d4, load low
// - 12 ab, 13 cd, 14 ef, 15 gh
// - power-on reset clears codes to zero
module octal_dac_control_registers
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic serial_clk,
    input wire logic frame_sync,
    input wire logic serial_data_in,
    input wire logic preset_apply_n,
    input wire logic output_load_n,
    output logic serial_echo,
    output logic [7:0][7:0] dac_input,
    output logic [7:0] amp_enable,
    output logic [7:0] fast_mode,
    output logic full_shutdown
);
    import dac_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------

    // take the converter code field and fold in the input format
    function automatic logic [7:0] code_of(input logic [11:0] data,
                                           input logic twos);
        logic [7:0] raw;
        raw = data[CODE_MSB:CODE_LSB];
        code_of = {raw[7] ^ twos, raw[6:0]};
    endfunction

    // pair index owning a converter, a/b -> 0 .. g/h -> 3
    function automatic logic [1:0] pair_of(input int dac);
        pair_of = 2'(dac / 2);
    endfunction

    // ----------------------------------------------------------------
    // crossings
    // ----------------------------------------------------------------
    logic [2:0] pins_sync;          // toggle, preset_n, load_n in mclk
    logic [1:0] link_sync;          // echo enable, reset in serial_clk
    logic word_toggle;              // toggles once per received word
    cmd_word_t rx_word;             // held stable between toggles
    logic toggle_seen;              // last toggle value acted on
    logic word_strobe;              // one mclk pulse per new word
    logic preset_low;               // synchronised preset request
    logic load_low;                 // synchronised load request
    logic link_rst_n;               // reset as seen on the link side
    global_ctrl_t global_ctrl;      // whole-device settings

    // async pins and the word toggle enter the mclk domain
    level_sync #(.WIDTH(3)) pin_sync_inst
    (
        .clk(mclk),
        .async_in({word_toggle, preset_apply_n, output_load_n}),
        .sync_out(pins_sync)
    );

    // echo enable and reset enter the serial clock domain
    level_sync #(.WIDTH(2)) link_sync_inst
    (
        .clk(serial_clk),
        .async_in({global_ctrl.echo_enable, rst_n}),
        .sync_out(link_sync)
    );

    assign link_rst_n = link_sync[0];
    assign preset_low = ~pins_sync[1];
    assign load_low = ~pins_sync[0];
    assign word_strobe = pins_sync[2] ^ toggle_seen;

    // ----------------------------------------------------------------
    // serial receiver
    // ----------------------------------------------------------------
    serial_word_receiver rx_inst
    (
        .serial_clk(serial_clk),
        .link_rst_n(link_rst_n),
        .frame_sync(frame_sync),
        .serial_data_in(serial_data_in),
        .echo_enable(link_sync[1]),
        .word(rx_word),
        .word_toggle(word_toggle),
        .serial_echo(serial_echo)
    );

    // ----------------------------------------------------------------
    // register bank state
    // ----------------------------------------------------------------
    logic [7:0] code_reg [NUM_DACS];       // stored converter codes
    logic [7:0] next_code_reg [NUM_DACS];
    global_ctrl_t next_global_ctrl;
    pair_ctrl_t pair_ctrl;                 // per-pair settings
    pair_ctrl_t next_pair_ctrl;
    logic [7:0] preset_code;               // shared preset value
    logic [7:0] next_preset_code;
    logic preset_written;                  // preset loaded since reset
    logic next_preset_written;
    logic next_toggle_seen;
    logic [7:0] new_code;                  // decoded code of this word
    logic [1:0] comp_pair;                 // pair of a complement write

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < NUM_DACS; i++)
            next_code_reg[i] = code_reg[i];
        next_global_ctrl = global_ctrl;
        next_pair_ctrl = pair_ctrl;
        next_preset_code = preset_code;
        next_preset_written = preset_written;
        next_toggle_seen = pins_sync[2];
        new_code = code_of(rx_word.data, global_ctrl.code_format_select);
        comp_pair = rx_word.addr[1:0];
        if (word_strobe)
        begin
            case (rx_word.addr)
                // single converter codes, a..h
                4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, ADDR_CODE_LAST:
                begin
                    next_code_reg[rx_word.addr[2:0]] = new_code;
                end
                // whole-device settings, reserved bits dropped
                ADDR_GLOBAL:
                begin
                    next_global_ctrl.full_shutdown_bit =
                        rx_word.data[GLB_SHUTDOWN_POS];
                    next_global_ctrl.echo_enable =
                        rx_word.data[GLB_ECHO_POS];
                    next_global_ctrl.code_format_select =
                        rx_word.data[GLB_FORMAT_POS];
                end
                // pair shutdown and speed
                ADDR_PAIR:
                begin
                    next_pair_ctrl.pair_shutdown_bit =
                        rx_word.data[PAIR_SHUT_LSB +: 4];
                    next_pair_ctrl.pair_speed_bit =
                        rx_word.data[PAIR_SPEED_LSB +: 4];
                end
                // shared preset value
                ADDR_PRESET:
                begin
                    next_preset_code = new_code;
                    next_preset_written = 1'b1;
                end
                // code plus complement on the partner
                ADDR_COMP_AB, ADDR_COMP_CD, ADDR_COMP_EF, ADDR_COMP_GH:
                begin
                    next_code_reg[{comp_pair, 1'b0}] = new_code;
                    next_code_reg[{comp_pair, 1'b1}] = ~new_code;
                end
                // reserved address: no effect
                default:
                begin
                    next_preset_written = preset_written;
                end
            endcase
        end
    end

    // register the bank; reset clears codes and controls
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_DACS; i++)
                code_reg[i] <= CODE_RESET;
            global_ctrl <= GLOBAL_RESET;
            pair_ctrl <= PAIR_RESET;
            preset_code <= CODE_RESET;
            preset_written <= 1'b0;
            toggle_seen <= SYNC_RESET;
        end
        else
        begin
            for (int i = 0; i < NUM_DACS; i++)
                code_reg[i] <= next_code_reg[i];
            global_ctrl <= next_global_ctrl;
            pair_ctrl <= next_pair_ctrl;
            preset_code <= next_preset_code;
            preset_written <= next_preset_written;
            toggle_seen <= next_toggle_seen;
        end
    end

    // ----------------------------------------------------------------
    // converter inputs and analogue controls
    // ----------------------------------------------------------------
    logic [7:0][7:0] next_dac_input;
    logic [7:0] next_amp_enable;
    logic [7:0] next_fast_mode;
    logic next_full_shutdown;
    logic [7:0] preset_effective;          // preset or zero scale

    always_comb
    begin
        next_dac_input = dac_input;
        // zero scale until a preset has been written
        preset_effective = preset_written ? preset_code
                                          : CODE_RESET;
        if (preset_low)
        begin
            // preset overrides every converter at once
            for (int i = 0; i < NUM_DACS; i++)
                next_dac_input[i] = preset_effective;
        end
        else if (load_low)
        begin
            // transparent transfer while load is held low
            for (int i = 0; i < NUM_DACS; i++)
                next_dac_input[i] = code_reg[i];
        end
        next_full_shutdown = global_ctrl.full_shutdown_bit;
        for (int i = 0; i < NUM_DACS; i++)
        begin
            // both amplifiers of a shut pair go off; full shutdown turns all eight off
            next_amp_enable[i] = ~(global_ctrl.full_shutdown_bit |
                pair_ctrl.pair_shutdown_bit[pair_of(i)]);
            next_fast_mode[i] =
                pair_ctrl.pair_speed_bit[pair_of(i)];
        end
    end

    // register the outputs
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            dac_input <= '0;
            amp_enable <= 8'h00;
            fast_mode <= 8'h00;
            full_shutdown <= 1'b0;
        end
        else
        begin
            dac_input <= next_dac_input;
            amp_enable <= next_amp_enable;
            fast_mode <= next_fast_mode;
            full_shutdown <= next_full_shutdown;
        end
    end

endmodule

`default_nettype wire

// ===== dac_ctrl_pkg.sv
/*
 * shared constants and types for the octal converter command decoder:
 * command word layout, address codes, control field positions and reset
 * values.
 * assumes a 16-bit command word, address in the top four bits.
 */
`default_nettype none

package dac_ctrl_pkg;

    // ----------------------------------------------------------------
    // word format
    // ----------------------------------------------------------------
    localparam int WORD_BITS = 16;          // bits in one command word
    localparam int ADDR_BITS = 4;           // address field width
    localparam int DATA_BITS = 12;          // data field width
    localparam int CODE_BITS = 8;           // converter code width
    localparam int NUM_DACS = 8;            // converters a..h
    localparam int NUM_PAIRS = 4;           // pairs ab, cd, ef, gh
    localparam int CODE_MSB = 11;           // code sits in d11..d4
    localparam int CODE_LSB = 4;
    localparam logic [4:0] LAST_BIT_COUNT = 5'h0f; // index of 16th bit

    // ----------------------------------------------------------------
    // address codes
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CODE_LAST = 4'h7;  // 0..7 single codes
    localparam logic [3:0] ADDR_GLOBAL = 4'h8;     // global_control
    localparam logic [3:0] ADDR_PAIR = 4'h9;       // pair_power_speed
    localparam logic [3:0] ADDR_PRESET = 4'ha;     // preset_value
    localparam logic [3:0] ADDR_RESERVED = 4'hb;   // no effect
    localparam logic [3:0] ADDR_COMP_AB = 4'hc;    // pair_ab_complement
    localparam logic [3:0] ADDR_COMP_CD = 4'hd;    // pair_cd_complement
    localparam logic [3:0] ADDR_COMP_EF = 4'he;    // pair_ef_complement
    localparam logic [3:0] ADDR_COMP_GH = 4'hf;    // pair_gh_complement

    // ----------------------------------------------------------------
    // control field positions
    // ----------------------------------------------------------------
    localparam int GLB_SHUTDOWN_POS = 4;    // full_shutdown_bit
    localparam int GLB_ECHO_POS = 3;        // serial echo enable
    localparam int GLB_FORMAT_POS = 0;      // code_format_select
    localparam int PAIR_SHUT_LSB = 4;       // pair_shutdown_bit d7..d4
    localparam int PAIR_SPEED_LSB = 0;      // pair_speed_bit d3..d0

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CODE_RESET = 8'h00;
    localparam logic [3:0] PAIR_FIELD_RESET = 4'h0;
    localparam logic SYNC_RESET = 1'b0;

    // one received command word
    typedef struct packed {
        logic [3:0] addr;
        logic [11:0] data;
    } cmd_word_t;

    // global control settings
    typedef struct packed {
        logic full_shutdown_bit;
        logic echo_enable;
        logic code_format_select;
    } global_ctrl_t;

    // per-pair settings, index 0 = ab .. 3 = gh
    typedef struct packed {
        logic [3:0] pair_shutdown_bit;
        logic [3:0] pair_speed_bit;
    } pair_ctrl_t;

    localparam global_ctrl_t GLOBAL_RESET = '{1'b0, 1'b0, 1'b0};
    localparam pair_ctrl_t PAIR_RESET = '{4'h0, 4'h0};

endpackage

`default_nettype wire

// ===== level_sync.sv
/*
 * two flip-flop synchroniser for a bundle of independent levels.
 * assumes each bit is a slow level or a toggle; no multi-bit coherence.
 */
`timescale 1ns/1ps
`default_nettype none

module level_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import dac_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // two stages
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] meta;   // first stage, read only by second stage

    // first stage feeds only the second
    always_ff @(posedge clk)
    begin
        meta <= async_in;
        sync_out <= meta;
    end

endmodule

`default_nettype wire

// ===== serial_word_receiver.sv
/*
 * serial side of the command decoder: shifts data on falling serial clock
 * edges while frame_sync is low, hands each 16-bit word over as a toggle,
 * and produces the delayed serial echo.
 * assumes a rising frame_sync cancels a partial word.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_word_receiver
(
    input wire logic serial_clk,
    input wire logic link_rst_n,
    input wire logic frame_sync,
    input wire logic serial_data_in,
    input wire logic echo_enable,
    output dac_ctrl_pkg::cmd_word_t word,
    output logic word_toggle,
    output logic serial_echo
);
    import dac_ctrl_pkg::*;

    logic [4:0] bit_count;                 // bits taken this frame
    logic [WORD_BITS-1:0] shift;           // frame shift register
    logic [WORD_BITS-1:0] echo_line;       // free-running delay line
    logic [4:0] next_bit_count;
    logic [WORD_BITS-1:0] next_shift;
    logic [WORD_BITS-1:0] next_echo_line;
    cmd_word_t next_word;
    logic next_word_toggle;
    logic next_serial_echo;

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    always_comb
    begin
        next_bit_count = bit_count;
        next_shift = shift;
        next_word = word;
        next_word_toggle = word_toggle;
        next_echo_line = {echo_line[WORD_BITS-2:0], serial_data_in};
        next_serial_echo = echo_enable & echo_line[WORD_BITS-1];
        if (!frame_sync)
        begin
            next_shift = {shift[WORD_BITS-2:0], serial_data_in};
            if (bit_count == LAST_BIT_COUNT)
            begin
                // 16th bit: whole word is ready for the system side
                next_word = next_shift;
                next_word_toggle = ~word_toggle;
                next_bit_count = 5'h00;
            end
            else
            begin
                next_bit_count = bit_count + 5'h01;
            end
        end
    end

    // counter restarts whenever the frame ends, even with no clock
    always_ff @(negedge serial_clk or posedge frame_sync)
    begin
        if (frame_sync)
            bit_count <= 5'h00;
        else
            bit_count <= next_bit_count;
    end

    // data path and hand-over registers
    always_ff @(negedge serial_clk)
    begin
        shift <= next_shift;
        echo_line <= next_echo_line;
        if (!link_rst_n)
        begin
            word <= '0;
            word_toggle <= 1'b0;
            serial_echo <= 1'b0;
        end
        else
        begin
            word <= next_word;
            word_toggle <= next_word_toggle;
            serial_echo <= next_serial_echo;
        end
    end

endmodule

`default_nettype wire

// ===== serial_host_model.sv
/* host model: sends 16-bit serial words msb first.
   assumes the decoder takes bits on falling serial_clk. */
`timescale 1ns/1ps
`default_nettype none
module serial_host_model
(
    output logic serial_clk,
    output logic frame_sync,
    output logic serial_data_in,
    input wire logic serial_echo
);
    logic [15:0] echo_seen; // echo bits caught during a frame
    initial
    begin
        serial_clk = 1'b1; // idle high between frames
        frame_sync = 1'b1;
        serial_data_in = 1'b0;
        echo_seen = '0;
    end
    // clocks with the frame idle; the link reset needs edges
    task automatic idle_clocks(input int n);
        #13;
        repeat (n)
        begin
            #40 serial_clk = 1'b0;
            #40 serial_clk = 1'b1;
        end
    endtask
    // n bits of w; frame stays low if keep is set
    task automatic send_bits(input logic [15:0] w, input int n,
                             input bit keep);
        #13 frame_sync = 1'b0;
        for (int i = 15; i > 15 - n; i--)
        begin
            serial_data_in = w[i]; // msb first
            #40 serial_clk = 1'b0;
            #40 serial_clk = 1'b1;
            echo_seen[i] = serial_echo;
        end
        if (!keep)
        begin
            frame_sync = 1'b1;
            serial_data_in = ~serial_data_in; // released line
        end
    endtask
endmodule
`default_nettype wire

// ===== octal_dac_checker_assertions.sv
/* checker on the decoder's ports.
   assumes rst_n is synchronous to mclk. */
`timescale 1ns/1ps
`default_nettype none
module octal_dac_checker
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic serial_clk,
    input wire logic frame_sync,
    input wire logic serial_data_in,
    input wire logic preset_apply_n,
    input wire logic output_load_n,
    input wire logic serial_echo,
    input wire logic [7:0][7:0] dac_input,
    input wire logic [7:0] amp_enable,
    input wire logic [7:0] fast_mode,
    input wire logic full_shutdown
);
    // reset clears every mclk output
    property p_reset_clear;
        @(posedge mclk) !rst_n |=> dac_input == '0 &&
            amp_enable == 8'h00 && fast_mode == 8'h00 && !full_shutdown;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("outputs not cleared by reset");
    property p_after_release;
        @(posedge mclk) disable iff (!rst_n)
            $rose(rst_n) |=> amp_enable == 8'hff && fast_mode == 8'h00;
    endproperty
    a_after_release: assert property (p_after_release)
        else $error("control defaults wrong after reset");
    property p_shut_amp;
        @(posedge mclk) disable iff (!rst_n)
            full_shutdown && $past(full_shutdown) |-> amp_enable == 8'h00;
    endproperty
    a_shut_amp: assert property (p_shut_amp)
        else $error("amplifier on in full shutdown");
    property p_amp_pairs;
        @(posedge mclk) disable iff (!rst_n)
            (amp_enable & 8'h55) == ((amp_enable >> 1) & 8'h55);
    endproperty
    a_amp_pairs: assert property (p_amp_pairs)
        else $error("pair amplifiers differ");
    property p_fast_pairs;
        @(posedge mclk) disable iff (!rst_n)
            (fast_mode & 8'h55) == ((fast_mode >> 1) & 8'h55);
    endproperty
    a_fast_pairs: assert property (p_fast_pairs)
        else $error("pair speeds differ");
    property p_preset_all;
        @(posedge mclk) disable iff (!rst_n)
            (!preset_apply_n) [*5] |-> dac_input == {8{dac_input[0]}};
    endproperty
    a_preset_all: assert property (p_preset_all)
        else $error("preset not on all converters");
    property p_zero_preset;
        @(posedge mclk) disable iff (!rst_n)
            $rose(rst_n) ##1 (!preset_apply_n) [*5] |-> dac_input == '0;
    endproperty
    a_zero_preset: assert property (p_zero_preset)
        else $error("unwritten preset not zero");
    property p_dac_hold;
        @(posedge mclk) disable iff (!rst_n)
            (preset_apply_n && output_load_n) [*5] |-> $stable(dac_input);
    endproperty
    a_dac_hold: assert property (p_dac_hold)
        else $error("converter input moved with pins high");
endmodule
bind octal_dac_control_registers octal_dac_checker chk_u
(
    .mclk(mclk), .rst_n(rst_n), .serial_clk(serial_clk),
    .frame_sync(frame_sync), .serial_data_in(serial_data_in),
    .preset_apply_n(preset_apply_n), .output_load_n(output_load_n),
    .serial_echo(serial_echo), .dac_input(dac_input),
    .amp_enable(amp_enable), .fast_mode(fast_mode),
    .full_shutdown(full_shutdown)
);
`default_nettype wire

// ===== octal_dac_control_registers_bench.sv
/* self-checking bench for the converter command decoder.
   assumes the host model makes the link clock and frames. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            n_errors++; \
            $display("wrong value at %0t: %h not %h", $time, g, e); \
        end \
    end
module octal_dac_control_registers_bench;
    import dac_ctrl_pkg::*;
    logic mclk = 1'b0; // 25 MHz
    logic rst_n = 1'b0;
    logic preset_apply_n = 1'b0; // low through reset
    logic output_load_n = 1'b1;
    wire logic serial_clk;
    wire logic frame_sync;
    wire logic serial_data_in;
    logic serial_echo;
    logic [7:0][7:0] dac_input;
    logic [7:0] amp_enable;
    logic [7:0] fast_mode;
    logic full_shutdown;
    logic [7:0][7:0] expd; // expected converter codes
    int n_errors = 0;
    int n_compared = 0;
    always #20 mclk = ~mclk;
    octal_dac_control_registers dut_u
    (
        .mclk(mclk), .rst_n(rst_n), .serial_clk(serial_clk),
        .frame_sync(frame_sync), .serial_data_in(serial_data_in),
        .preset_apply_n(preset_apply_n), .output_load_n(output_load_n),
        .serial_echo(serial_echo), .dac_input(dac_input),
        .amp_enable(amp_enable), .fast_mode(fast_mode),
        .full_shutdown(full_shutdown)
    );
    serial_host_model host_u
    (
        .serial_clk(serial_clk), .frame_sync(frame_sync),
        .serial_data_in(serial_data_in), .serial_echo(serial_echo)
    );
    // one command word, then time for sync, decode and outputs
    task automatic wr(input logic [3:0] a, input logic [11:0] d);
        host_u.send_bits({a, d}, 16, 1'b0);
        repeat (10) @(negedge mclk);
    endtask
    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
        begin
            $display("[ PASS ]");
        end
        else
        begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // cuts a hang short
    initial
    begin
        #200us;
        n_errors++;
        report_and_stop();
    end
    initial
    begin
        fork
            host_u.idle_clocks(10);
            begin
                repeat (8) @(negedge mclk);
                rst_n = 1'b1;
            end
        join
        repeat (6) @(negedge mclk);
        `CHK(dac_input, 64'h0)
        `CHK(amp_enable, 8'hff)
        `CHK({fast_mode, full_shutdown, serial_echo}, 10'h0)
        preset_apply_n = 1'b1;
        repeat (6) @(negedge mclk);
        expd = '0;
        `CHK(dac_input, expd)
        $display("test reset done");
        // code writes, load held off first
        wr(4'h0, 12'h3cf);
        `CHK(dac_input, expd)
        output_load_n = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            expd[i] = 8'(8'h11 * (i + 1));
            wr(4'(i), {expd[i], 4'ha});
        end
        `CHK(dac_input, expd)
        for (int p = 0; p < 4; p++)
        begin
            expd[2 * p] = 8'h5a + 8'(p);
            expd[2 * p + 1] = ~expd[2 * p];
            wr(4'hc + 4'(p), {expd[2 * p], 4'h0});
        end
        `CHK(dac_input, expd)
        `CHK(dac_input[3:2], 16'ha45b)
        $display("test codes done");
        // pairs ab and gh off, ef and gh fast, reserved bits set
        wr(4'h9, 12'hf9c);
        `CHK(amp_enable, 8'h3c)
        `CHK(amp_enable[3:2], 2'b11)
        `CHK(fast_mode, 8'hf0)
        wr(4'h8, 12'hff6);
        `CHK(full_shutdown, 1'b1)
        `CHK(amp_enable, 8'h00)
        wr(4'h8, 12'h001);
        `CHK(amp_enable, 8'h3c)
        wr(4'h0, 12'h050);
        expd[0] = 8'h85;
        `CHK(dac_input, expd)
        wr(4'h8, 12'h000);
        wr(4'h0, 12'h050);
        expd[0] = 8'h05;
        `CHK(dac_input, expd)
        $display("test control done");
        // frame cut after 8 bits is dropped
        host_u.send_bits(16'h1ee0, 8, 1'b0);
        repeat (10) @(negedge mclk);
        `CHK(dac_input, expd)
        wr(4'ha, 12'hc30);
        preset_apply_n = 1'b0;
        repeat (6) @(negedge mclk);
        `CHK(dac_input, {8{8'hc3}})
        preset_apply_n = 1'b1;
        repeat (6) @(negedge mclk);
        `CHK(dac_input, expd)
        $display("test preset done");
        // echo on; reserved address words back to back
        wr(4'h8, 12'h008);
        host_u.idle_clocks(4);
        host_u.send_bits(16'hbc35, 16, 1'b1);
        host_u.send_bits(16'hb123, 16, 1'b0);
        `CHK(host_u.echo_seen, 16'hbc35)
        repeat (10) @(negedge mclk);
        `CHK(dac_input, expd)
        $display("test echo done");
        report_and_stop();
    end
endmodule
`default_nettype wire
